// [rtl/adt_top.sv]
`include "adt_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module adt_top
   import adt_pkg::*;
#(
   parameter int NUM_CH = 8
) (
   // Clock and reset
   input wire logic MCLK,
   input wire logic ARST_N,
   // AXI4-Lite write
   input wire logic [7:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   // AXI4-Lite read
   input wire logic [7:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   // Trigger sources
   input wire logic [1:0] TRIG_PIN,
   input wire logic TIMER0_MATCH1_SIGNAL,
   input wire logic TIMER0_MATCH3_SIGNAL,
   input wire logic TIMER1_MATCH0_SIGNAL,
   input wire logic TIMER1_MATCH1_SIGNAL,
   // Analog converter core
   output logic CONV_START,
   output logic [2:0] CONV_CHAN,
   input wire logic CONV_DONE,
   input wire logic [9:0] CONV_DATA,
   // Pin isolation
   output logic [7:0] ANALOG_CONNECT,
   // Interrupts
   output logic VECTORED_IRQ_REQ,
   output logic IRQ
);
   if (NUM_CH < 1 || NUM_CH > 8) begin : g_bad_ch
      $error("NUM_CH must be 1 to 8");
   end
   localparam logic [7:0] CH_MASK = 8'((9'h1 << NUM_CH) - 9'h1);

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return res;
   endfunction
   // Next enabled channel above cur, wrapping; channel 0 if none
   function automatic logic [2:0] next_ch(input logic [7:0] sel, input logic [2:0] cur);
      logic [2:0] idx;
      logic found;
      logic [2:0] res;
      found = 1'b0;
      res = 3'h0;
      for (int i = 1; i <= 8; i++) begin
         idx = cur + 3'(i);
         if (!found && sel[idx]) begin
            res = idx;
            found = 1'b1;
         end
      end
      return res;
   endfunction

   // Bus state
   logic aw_held;
   logic [7:0] aw_addr;
   logic w_held;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic bvalid;
   logic [1:0] bresp;
   logic rvalid;
   logic [31:0] rdata;
   logic [1:0] rresp;

   // Block state
   adt_ctrl_s ctrl;
   adt_result_s result;
   adt_state_e state;
   logic [2:0] scan_ptr;
   logic sw_pend;
   logic conv_start;
   logic [2:0] conv_chan;
   logic [`ADT_EVT_W-1:0] stat;
   logic [`ADT_EVT_W-1:0] mask;
   logic [7:0] analog_sel;

   // Write decode
   logic wr_fire;
   logic wr_ctrl;
   logic wr_stat;
   logic wr_mask;
   logic wr_pinfn;
   logic wr_hit;
   assign AWREADY = !aw_held;
   assign WREADY = !w_held;
   assign wr_fire = aw_held && w_held && !bvalid;
   assign wr_ctrl = wr_fire && (aw_addr == `ADT_OFF_CTRL);
   assign wr_stat = wr_fire && (aw_addr == `ADT_OFF_STAT);
   assign wr_mask = wr_fire && (aw_addr == `ADT_OFF_MASK);
   assign wr_pinfn = wr_fire && (aw_addr == `ADT_OFF_PINFN);
   assign wr_hit = wr_ctrl || wr_stat || wr_mask || wr_pinfn || (aw_addr == `ADT_OFF_RESULT);

   // Register words
   logic [31:0] ctrl_word;
   logic [31:0] ctrl_merged;
   logic [31:0] result_word;
   adt_ctrl_s ctrl_new;
   assign ctrl_word = (32'(ctrl.sel) << `ADT_CTRL_SEL_LSB) | (32'(ctrl.burst) << `ADT_CTRL_BURST_BIT)
      | (32'(ctrl.start) << `ADT_CTRL_START_LSB) | (32'(ctrl.edge_fall) << `ADT_CTRL_EDGE_BIT);
   assign ctrl_merged = merge(ctrl_word, w_data, w_strb);
   assign ctrl_new.sel = ctrl_merged[`ADT_CTRL_SEL_LSB +: 8] & CH_MASK;
   assign ctrl_new.burst = ctrl_merged[`ADT_CTRL_BURST_BIT];
   assign ctrl_new.start = ctrl_merged[`ADT_CTRL_START_LSB +: 3];
   assign ctrl_new.edge_fall = ctrl_merged[`ADT_CTRL_EDGE_BIT];
   assign result_word = (32'(result.data) << `ADT_RES_DATA_LSB) | (32'(result.chan) << `ADT_RES_CHN_LSB)
      | (32'(result.overrun) << `ADT_RES_OVR_BIT) | (32'(result.done) << `ADT_RES_DONE_BIT);

   // Read decode
   logic rd_fire;
   logic rd_result;
   logic rd_hit;
   logic [31:0] rd_mux;
   assign ARREADY = !rvalid;
   assign rd_fire = ARVALID && !rvalid;
   assign rd_result = rd_fire && (ARADDR == `ADT_OFF_RESULT);
   assign rd_mux = (ARADDR == `ADT_OFF_CTRL) ? ctrl_word :
      (ARADDR == `ADT_OFF_RESULT) ? result_word :
      (ARADDR == `ADT_OFF_STAT) ? 32'(stat) :
      (ARADDR == `ADT_OFF_MASK) ? 32'(mask) :
      (ARADDR == `ADT_OFF_PINFN) ? 32'(analog_sel) : 32'h0000_0000;
   assign rd_hit = (ARADDR == `ADT_OFF_CTRL) || (ARADDR == `ADT_OFF_RESULT) || (ARADDR == `ADT_OFF_STAT)
      || (ARADDR == `ADT_OFF_MASK) || (ARADDR == `ADT_OFF_PINFN);

   // Trigger edge detectors, one per source
   logic [5:0] trig_src;
   logic [5:0] trig_rise;
   assign trig_src = {TIMER1_MATCH1_SIGNAL, TIMER1_MATCH0_SIGNAL, TIMER0_MATCH3_SIGNAL,
      TIMER0_MATCH1_SIGNAL, TRIG_PIN};
   for (genvar g = 0; g < 6; g++) begin : g_edge
      adt_trig_edge u_edge (
         .MCLK(MCLK),
         .ARST_N(ARST_N),
         .TRIG_IN(trig_src[g]),
         .INVERT(ctrl.edge_fall),
         .RISE(trig_rise[g])
      );
   end

   // Start selection
   logic [2:0] trig_idx;
   logic hw_start;
   logic burst_start;
   logic start_req;
   logic start_go;
   logic done_set;
   logic done_clr;
   logic [2:0] pick_ch;
   assign trig_idx = ctrl.start - `ADT_START_PIN0;
   assign hw_start = !ctrl.burst && (ctrl.start >= `ADT_START_PIN0) && trig_rise[trig_idx];
   assign burst_start = ctrl.burst && (state == ADT_IDLE) && !wr_ctrl;
   assign start_req = hw_start || sw_pend || burst_start;
   assign start_go = start_req && (state == ADT_IDLE);
   assign pick_ch = next_ch(ctrl.sel, ctrl.burst ? scan_ptr : `ADT_SCAN_RESET);
   assign done_set = (state == ADT_BUSY) && CONV_DONE;
   assign done_clr = rd_result || wr_ctrl;

   // Events
   logic [`ADT_EVT_W-1:0] events;
   logic [`ADT_EVT_W-1:0] w1c;
   assign events[`ADT_EVT_DONE] = done_set;
   assign events[`ADT_EVT_OVR] = done_set && result.done && !rd_result;
   assign events[`ADT_EVT_LOST] = start_req && !burst_start && (state == ADT_BUSY);
   assign w1c = wr_stat ? (w_data[`ADT_EVT_W-1:0] & {`ADT_EVT_W{w_strb[0]}}) : '0;

   // Bus write channel
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         aw_held <= 1'b0;
         aw_addr <= 8'h00;
         w_held <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else begin
         if (AWVALID && !aw_held) begin
            aw_held <= 1'b1;
            aw_addr <= AWADDR;
         end else if (wr_fire) begin
            aw_held <= 1'b0;
         end
         if (WVALID && !w_held) begin
            w_held <= 1'b1;
            w_data <= WDATA;
            w_strb <= WSTRB;
         end else if (wr_fire) begin
            w_held <= 1'b0;
         end
      end
   end

   // Bus responses
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         bvalid <= 1'b0;
         bresp <= `ADT_RESP_OKAY;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= `ADT_RESP_OKAY;
      end else begin
         if (wr_fire) begin
            bvalid <= 1'b1;
            bresp <= wr_hit ? `ADT_RESP_OKAY : `ADT_RESP_SLVERR;
         end else if (BREADY) begin
            bvalid <= 1'b0;
         end
         if (rd_fire) begin
            rvalid <= 1'b1;
            rdata <= rd_mux;
            rresp <= rd_hit ? `ADT_RESP_OKAY : `ADT_RESP_SLVERR;
         end else if (RREADY) begin
            rvalid <= 1'b0;
         end
      end
   end

   // Software registers
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ctrl <= '0;
         mask <= `ADT_MASK_RESET;
         analog_sel <= `ADT_PINFN_RESET;
         sw_pend <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            ctrl <= ctrl_new;
         end
         if (wr_mask) begin
            mask <= w_strb[0] ? w_data[`ADT_EVT_W-1:0] : mask;
         end
         if (wr_pinfn) begin
            analog_sel <= w_strb[0] ? w_data[7:0] : analog_sel;
         end
         sw_pend <= wr_ctrl && !ctrl_new.burst && (ctrl_new.start == `ADT_START_NOW);
      end
   end

   // Conversion sequencing
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         state <= ADT_IDLE;
         conv_start <= 1'b0;
         conv_chan <= 3'h0;
         scan_ptr <= `ADT_SCAN_RESET;
      end else begin
         conv_start <= 1'b0;
         case (state)
            ADT_IDLE: begin
               if (start_go) begin
                  state <= ADT_BUSY;
                  conv_start <= 1'b1;
                  conv_chan <= pick_ch;
                  scan_ptr <= pick_ch;
               end else if (wr_ctrl) begin
                  scan_ptr <= `ADT_SCAN_RESET;
               end
            end
            ADT_BUSY: begin
               if (CONV_DONE) begin
                  state <= ADT_IDLE;
               end
            end
            default: state <= ADT_IDLE;
         endcase
      end
   end

   // Result, done flag and event status; a new completion beats a clear
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         result <= '0;
         stat <= '0;
      end else begin
         if (done_set) begin
            result.done <= 1'b1;
            result.data <= CONV_DATA;
            result.chan <= conv_chan;
         end else if (done_clr) begin
            result.done <= 1'b0;
         end
         if (events[`ADT_EVT_OVR]) begin
            result.overrun <= 1'b1;
         end else if (rd_result) begin
            result.overrun <= 1'b0;
         end
         stat <= (stat & ~w1c) | events;
      end
   end
   assign BVALID = bvalid;
   assign BRESP = bresp;
   assign RVALID = rvalid;
   assign RDATA = rdata;
   assign RRESP = rresp;
   assign CONV_START = conv_start;
   assign CONV_CHAN = conv_chan;
   assign ANALOG_CONNECT = analog_sel;
   assign VECTORED_IRQ_REQ = result.done;
   assign IRQ = |(stat & mask);
endmodule
`default_nettype wire

// [rtl/adt_consts.svh]
`ifndef ADT_CONSTS_SVH
`define ADT_CONSTS_SVH

// Register byte offsets
`define ADT_OFF_CTRL 8'h00
`define ADT_OFF_RESULT 8'h04
`define ADT_OFF_STAT 8'h08
`define ADT_OFF_MASK 8'h0c
`define ADT_OFF_PINFN 8'h10

// Control register fields
`define ADT_CTRL_SEL_LSB 0
`define ADT_CTRL_BURST_BIT 16
`define ADT_CTRL_START_LSB 24
`define ADT_CTRL_EDGE_BIT 27

// Result register fields
`define ADT_RES_DATA_LSB 6
`define ADT_RES_CHN_LSB 24
`define ADT_RES_OVR_BIT 30
`define ADT_RES_DONE_BIT 31

// Start field codes
`define ADT_START_NONE 3'h0
`define ADT_START_NOW 3'h1
`define ADT_START_PIN0 3'h2

// Event bits of status and mask
`define ADT_EVT_DONE 0
`define ADT_EVT_OVR 1
`define ADT_EVT_LOST 2
`define ADT_EVT_W 3

// Reset values
`define ADT_PINFN_RESET 8'h00
`define ADT_MASK_RESET 3'h0
`define ADT_SCAN_RESET 3'h7

// Bus answers
`define ADT_RESP_OKAY 2'h0
`define ADT_RESP_SLVERR 2'h2

`endif

// [rtl/adt_pkg.sv]
package adt_pkg;

   typedef enum logic {ADT_IDLE, ADT_BUSY} adt_state_e;

   typedef struct packed {
      logic edge_fall;
      logic [2:0] start;
      logic burst;
      logic [7:0] sel;
   } adt_ctrl_s;

   typedef struct packed {
      logic done;
      logic overrun;
      logic [2:0] chan;
      logic [9:0] data;
   } adt_result_s;

endpackage

// [rtl/adt_trig_edge.sv]
`timescale 1ns/100ps
`default_nettype none
module adt_trig_edge (
   // Clock and reset
   input wire logic MCLK,
   input wire logic ARST_N,
   // Trigger
   input wire logic TRIG_IN,
   input wire logic INVERT,
   output logic RISE
);
   logic meta;
   logic sync;
   logic prev;
   logic level;

   assign level = sync ^ INVERT;
   assign RISE = level & ~prev;

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         meta <= 1'b0;
         sync <= 1'b0;
         prev <= 1'b1;
      end else begin
         meta <= TRIG_IN;
         sync <= meta;
         prev <= level;
      end
   end
endmodule
`default_nettype wire

// [tb/adt_top_sva.sv]
`timescale 1ns/100ps
`default_nettype none
`include "adt_consts.svh"
module adt_top_sva (
   // Clock and reset
   input wire logic MCLK,
   input wire logic ARST_N,
   // Register bus
   input wire logic [7:0] AWADDR,
   input wire logic AWVALID,
   input wire logic AWREADY,
   input wire logic WVALID,
   input wire logic WREADY,
   input wire logic BVALID,
   input wire logic [7:0] ARADDR,
   input wire logic ARVALID,
   input wire logic ARREADY,
   input wire logic RVALID,
   // Converter and interrupt
   input wire logic CONV_START,
   input wire logic CONV_DONE,
   input wire logic VECTORED_IRQ_REQ
);
   logic busy;
   // Tracks a conversion in flight, as seen at the core handshake
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         busy <= 1'b0;
      end else if (CONV_START) begin
         busy <= 1'b1;
      end else if (CONV_DONE) begin
         busy <= 1'b0;
      end
   end
   default clocking @(posedge MCLK); endclocking
   default disable iff (!ARST_N);
   property p_done_irq; CONV_DONE && busy |=> VECTORED_IRQ_REQ; endproperty
   a_done_irq: assert property (p_done_irq) else $error("no irq after done");
   property p_irq_cause; !VECTORED_IRQ_REQ && !(CONV_DONE && busy) |=> !VECTORED_IRQ_REQ; endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("irq without done");
   property p_rd_clr;
      ARVALID && ARREADY && ARADDR == `ADT_OFF_RESULT && !busy |-> ##[1:2] !VECTORED_IRQ_REQ;
   endproperty
   a_rd_clr: assert property (p_rd_clr) else $error("irq kept after read");
   property p_wr_clr;
      AWVALID && AWREADY && WVALID && WREADY && AWADDR == `ADT_OFF_CTRL && !busy |-> ##[1:3] !VECTORED_IRQ_REQ;
   endproperty
   a_wr_clr: assert property (p_wr_clr) else $error("irq kept after write");
   property p_pulse; CONV_START |=> !CONV_START; endproperty
   a_pulse: assert property (p_pulse) else $error("start too long");
   property p_one; busy |-> !CONV_START; endproperty
   a_one: assert property (p_one) else $error("start while busy");
   property p_bresp; AWVALID && AWREADY && WVALID && WREADY |-> ##[1:2] BVALID; endproperty
   a_bresp: assert property (p_bresp) else $error("no write response");
   property p_rresp; ARVALID && ARREADY |=> RVALID; endproperty
   a_rresp: assert property (p_rresp) else $error("no read response");
endmodule
`default_nettype wire

// [tb/adt_conv_model.sv]
`timescale 1ns/100ps
`default_nettype none
module adt_conv_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Core handshake
   input wire logic start,
   input wire logic slow,
   output logic done,
   output logic [9:0] data,
   output logic [9:0] last
);
   logic [3:0] cnt;
   // Data toggles outside the done cycle so a late sample is caught
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 4'h0;
         done <= 1'b0;
         data <= 10'h0;
         last <= 10'h0;
      end else begin
         done <= 1'b0;
         data <= ~data;
         if (start) begin
            cnt <= slow ? 4'hc : 4'h3;
         end else if (cnt == 4'h1) begin
            done <= 1'b1;
            data <= last + 10'h1;
            last <= last + 10'h1;
            cnt <= 4'h0;
         end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

// [tb/adt_trigger_and_done_irq_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
`include "adt_consts.svh"
module adt_trigger_and_done_irq_tb_top;
   localparam logic [31:0] RM = 32'h8700ffc0;
   logic MCLK = 1'b0, ARST_N = 1'b0, slow = 1'b0;
   logic [7:0] AWADDR = 8'h0, ARADDR = 8'h0;
   logic [31:0] WDATA = 32'h0;
   logic [3:0] WSTRB = 4'hf;
   logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
   logic AWREADY, WREADY, BVALID, ARREADY, RVALID, CONV_START, CONV_DONE, IRQ, VECTORED_IRQ_REQ;
   logic [1:0] BRESP, RRESP, TRIG_PIN;
   logic [31:0] RDATA;
   logic [5:0] src = 6'h0;
   logic TIMER0_MATCH1_SIGNAL, TIMER0_MATCH3_SIGNAL, TIMER1_MATCH0_SIGNAL, TIMER1_MATCH1_SIGNAL;
   logic [2:0] CONV_CHAN;
   logic [9:0] CONV_DATA, last;
   logic [7:0] ANALOG_CONNECT;
   int error_cnt = 0, n_tests = 0;
   logic [1:0] bq[$];
   logic [33:0] rq[$];
   logic [31:0] mq[$];
   assign {TIMER1_MATCH1_SIGNAL, TIMER1_MATCH0_SIGNAL, TIMER0_MATCH3_SIGNAL, TIMER0_MATCH1_SIGNAL, TRIG_PIN} = src;
   adt_top u_adt_top (.MCLK(MCLK), .ARST_N(ARST_N), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
      .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
      .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
      .RVALID(RVALID), .RREADY(RREADY), .TRIG_PIN(TRIG_PIN), .TIMER0_MATCH1_SIGNAL(TIMER0_MATCH1_SIGNAL),
      .TIMER0_MATCH3_SIGNAL(TIMER0_MATCH3_SIGNAL), .TIMER1_MATCH0_SIGNAL(TIMER1_MATCH0_SIGNAL),
      .TIMER1_MATCH1_SIGNAL(TIMER1_MATCH1_SIGNAL), .CONV_START(CONV_START), .CONV_CHAN(CONV_CHAN),
      .CONV_DONE(CONV_DONE), .CONV_DATA(CONV_DATA), .ANALOG_CONNECT(ANALOG_CONNECT),
      .VECTORED_IRQ_REQ(VECTORED_IRQ_REQ), .IRQ(IRQ));
   adt_conv_model u_adt_conv_model (.clk(MCLK), .rst_n(ARST_N), .start(CONV_START), .slow(slow),
      .done(CONV_DONE), .data(CONV_DATA), .last(last));
   initial forever #10 MCLK = ~MCLK;
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("checks=%0d errors=%0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic tmo();
      error_cnt++;
      end_sim();
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] r,
                      input logic [31:0] m);
      int i;
      @(posedge MCLK);
      if (w) begin
         bq.push_back(r);
         AWADDR <= a;
         WDATA <= d;
         AWVALID <= 1'b1;
         WVALID <= 1'b1;
         BREADY <= 1'b1;
      end else begin
         rq.push_back({r, d & m});
         mq.push_back(m);
         ARADDR <= a;
         ARVALID <= 1'b1;
         RREADY <= 1'b1;
      end
      for (i = 0; i < 40; i++) begin
         @(posedge MCLK);
         if (AWREADY) AWVALID <= 1'b0;
         if (WREADY) WVALID <= 1'b0;
         if (ARREADY) ARVALID <= 1'b0;
         if ((BVALID && BREADY) || (RVALID && RREADY)) break;
      end
      BREADY <= 1'b0;
      RREADY <= 1'b0;
      if (i == 40) tmo();
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, `ADT_RESP_OKAY, 32'h0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
      bus(1'b0, a, d, `ADT_RESP_OKAY, m);
   endtask
   // Waits for a start pulse (s=0) or the done request (s=1)
   task automatic wt(input logic s, input logic [2:0] ch);
      int i;
      for (i = 0; i < 40 && (s ? VECTORED_IRQ_REQ : CONV_START) !== 1'b1; i++) @(posedge MCLK);
      if (i == 40) tmo();
      if (!s) chk(CONV_CHAN, ch);
      @(posedge MCLK);
   endtask
   task automatic quiet(input int n);
      logic [7:0] s;
      s = 8'h0;
      repeat (n) begin
         @(posedge MCLK);
         s += {7'h0, CONV_START};
      end
      chk(s, 0);
   endtask
   function automatic logic [31:0] res(input logic [2:0] ch);
      return {1'b1, 4'h0, ch, 8'h0, last, 6'h0};
   endfunction
   always @(posedge MCLK) begin
      if (BVALID && BREADY) chk(BRESP, bq.pop_front());
      if (RVALID && RREADY) chk({RRESP, RDATA & mq.pop_front()}, rq.pop_front());
   end
   initial begin
      int c, e, k;
      logic [7:0] v;
      void'($urandom(32'h0cf7cb77));
      repeat (8) @(posedge MCLK);
      ARST_N <= 1'b1;
      chk({IRQ, VECTORED_IRQ_REQ, ANALOG_CONNECT}, 0);
      bus(1'b0, 8'h14, 0, `ADT_RESP_SLVERR, 32'hffffffff);
      bus(1'b1, 8'h14, 1, `ADT_RESP_SLVERR, 0);
      v = 8'($urandom);
      wr(`ADT_OFF_PINFN, v);
      rd(`ADT_OFF_PINFN, v, 32'hff);
      chk(ANALOG_CONNECT, v);
      wr(`ADT_OFF_MASK, 1);
      wr(`ADT_OFF_CTRL, 32'h0100_0004);
      wt(0, 2);
      rd(`ADT_OFF_CTRL, 32'h0100_0004, 32'h0f0100ff);
      wt(1, 0);
      chk(IRQ, 1);
      rd(`ADT_OFF_STAT, 1, 7);
      rd(`ADT_OFF_RESULT, res(2), RM);
      @(posedge MCLK);
      chk(VECTORED_IRQ_REQ, 0);
      wr(`ADT_OFF_MASK, 0);
      chk(IRQ, 0);
      wr(`ADT_OFF_STAT, 1);
      rd(`ADT_OFF_STAT, 0, 7);
      // Idle level first so the control write itself makes no edge
      for (c = 2; c < 8; c++) for (e = 0; e < 2; e++) begin
         k = $urandom_range(7);
         wr(`ADT_OFF_CTRL, 0);
         src <= {6{e[0]}};
         wr(`ADT_OFF_CTRL, {4'h0, e[0], c[2:0], 16'h0, 8'h1 << k});
         quiet(6);
         src[c - 2] <= ~e[0];
         wt(0, k[2:0]);
         wt(1, 0);
         rd(`ADT_OFF_RESULT, res(k[2:0]), RM);
         src[c - 2] <= e[0];
         quiet(8);
      end
      slow <= 1'b1;
      wr(`ADT_OFF_STAT, 7);
      wr(`ADT_OFF_CTRL, 32'h0001_0005);
      for (k = 0; k < 3; k++) wt(0, k[0] ? 3'h2 : 3'h0);
      wr(`ADT_OFF_CTRL, 0);
      wt(1, 0);
      rd(`ADT_OFF_STAT, 3, 7);
      rd(`ADT_OFF_RESULT, res(0), RM);
      quiet(14);
      wr(`ADT_OFF_STAT, 7);
      wr(`ADT_OFF_CTRL, 32'h0100_0001);
      wt(0, 0);
      wr(`ADT_OFF_CTRL, 32'h0100_0001);
      wt(1, 0);
      wr(`ADT_OFF_CTRL, 0);
      chk(VECTORED_IRQ_REQ, 0);
      rd(`ADT_OFF_STAT, 5, 7);
      end_sim();
   end
endmodule
bind adt_top adt_top_sva u_adt_top_sva (.MCLK(MCLK), .ARST_N(ARST_N), .AWADDR(AWADDR), .AWVALID(AWVALID),
   .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID), .ARADDR(ARADDR), .ARVALID(ARVALID),
   .ARREADY(ARREADY), .RVALID(RVALID), .CONV_START(CONV_START), .CONV_DONE(CONV_DONE),
   .VECTORED_IRQ_REQ(VECTORED_IRQ_REQ));
`default_nettype wire
